// *** hw/annunciator_panel.v ***
// annunciator front-panel control: status led, lamp test, acknowledge, group select
`timescale 1ns/1ns
`default_nettype none
`include "annunciator_panel_regs.vh"
// How it works
// - status pair: red link fault, green receiving, flashing green on comm loss
// - status pair alternates red/green with no application or in group select
// - lamp test held repeats column test then individual led test forever
// - left column one second, right one second; pair done twice
// - horn sounds only in second column run of first test cycle
// - one led per half second: left column down, status pair, right column up
// - after individual test the cycle restarts at column test
// - releasing lamp test ends the test at once
// - local acknowledge steadies flashing active leds and silences horn
// - local acknowledge is never sent onto the link
// - link global acknowledge steadies leds and silences horn
// - after acknowledge horn stays off until a new event with its horn flag set arrives
// - four groups; three and four fixed maps, one and two custom
// - each group monitors thirty-two link events
// - assigned group resets to group four
// - in group select, selected-group events are held until exit
// - new assignment applies immediately without restart
// - status pair alternates at 2 hz throughout group select
// - both buttons held three seconds enters group select
// - entry confirmed by flashing top four rows four times at 1 s
// - rows 1-4: left solid for assigned, right for selected; others off
// - lamp test steps group one way, acknowledge the other, wrapping
// - fifteen seconds without a press exits and discards the selection
// - both held three seconds in select stores selection then exits
// - any exit flashes all sixteen rows three seconds then resumes
module annunciator_panel #(
	parameter ROWS = 16,
	parameter EVENTS = 32,
	parameter MS_CYC = `CYC_PER_MS
) (
	input wire core_clk_i,
	input wire reset_n_i,
	input wire lamp_test_button_i,
	input wire ack_button_i,
	input wire link_fault_i,
	input wire link_rx_active_i,
	input wire link_lost_i,
	input wire app_loaded_i,
	input wire global_ack_i,
	input wire [EVENTS-1:0] event_active_i,
	input wire [EVENTS-1:0] event_horn_i,
	input wire [1:0] event_group_i,
	output reg [ROWS-1:0] left_led_o,
	output reg [ROWS-1:0] right_led_o,
	output reg status_red_o,
	output reg status_green_o,
	output reg horn_o,
	output reg [1:0] assigned_group_o,
	output reg group_select_mode_o,
	output reg group_is_custom_o
);
	localparam S_NORMAL = 5'h01;
	localparam S_LAMP = 5'h02;
	localparam S_CONFIRM = 5'h04;
	localparam S_SELECT = 5'h08;
	localparam S_EXIT = 5'h10;
	localparam [31:0] MS_W = MS_CYC;
	localparam LED_STEPS = 2 * ROWS + 2;

	// millisecond tick shared by all timers
	reg [31:0] pre_ff;
	reg ms_tick_ff;
	always @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			pre_ff <= 32'h0;
			ms_tick_ff <= 1'b0;
		end
		else
		begin
			ms_tick_ff <= (pre_ff == MS_W - 32'h1);
			pre_ff <= (pre_ff == MS_W - 32'h1) ? 32'h0 : pre_ff + 32'h1;
		end
	end

	// two-stage sync then 20 ms stability debounce
	reg [1:0] lt_sync_ff, ak_sync_ff;
	reg lt_ff, ak_ff, lt_d_ff, ak_d_ff;
	reg [4:0] lt_cnt_ff, ak_cnt_ff;
	always @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			lt_sync_ff <= 2'h0;
			ak_sync_ff <= 2'h0;
			lt_ff <= 1'b0;
			ak_ff <= 1'b0;
			lt_d_ff <= 1'b0;
			ak_d_ff <= 1'b0;
			lt_cnt_ff <= 5'h0;
			ak_cnt_ff <= 5'h0;
		end
		else
		begin
			lt_sync_ff <= {lt_sync_ff[0], lamp_test_button_i};
			ak_sync_ff <= {ak_sync_ff[0], ack_button_i};
			lt_d_ff <= lt_ff;
			ak_d_ff <= ak_ff;
			if (lt_sync_ff[1] == lt_ff)
				lt_cnt_ff <= 5'h0;
			else if (ms_tick_ff)
			begin
				if (lt_cnt_ff == `T_DEBOUNCE_MS - 1)
					lt_ff <= lt_sync_ff[1];
				lt_cnt_ff <= lt_cnt_ff + 5'h1;
			end
			if (ak_sync_ff[1] == ak_ff)
				ak_cnt_ff <= 5'h0;
			else if (ms_tick_ff)
			begin
				if (ak_cnt_ff == `T_DEBOUNCE_MS - 1)
					ak_ff <= ak_sync_ff[1];
				ak_cnt_ff <= ak_cnt_ff + 5'h1;
			end
		end
	end

	wire both_w = lt_ff & ak_ff;
	// a press counts at release so a two-button hold never becomes a step
	wire lt_rel_w = lt_d_ff & ~lt_ff;
	wire ak_rel_w = ak_d_ff & ~ak_ff;

	reg [4:0] st_ff;
	reg [15:0] tmr_ff;
	reg [15:0] hold_ff;
	reg combo_ff;
	reg [1:0] sel_ff;
	reg [1:0] lamp_cyc_ff;
	reg [5:0] lamp_step_ff;
	reg first_cycle_ff;
	reg [EVENTS-1:0] acked_ff, prev_ev_ff;
	reg silenced_ff;
	reg [8:0] blink_ff;
	reg blink_ff_ph;

	// group select holds off annunciation of events from the selected group
	wire defer_w = (st_ff == S_SELECT || st_ff == S_CONFIRM) && event_group_i == sel_ff;
	wire [EVENTS-1:0] ev_w = defer_w ? {EVENTS{1'b0}} : event_active_i;
	wire [EVENTS-1:0] new_ev_w = ev_w & ~prev_ev_ff;
	wire any_ack_w = (st_ff == S_NORMAL && ak_rel_w && !combo_ff) || global_ack_i;

	// 2 hz alternation: 250 ms half period
	always @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			blink_ff <= 9'h0;
			blink_ff_ph <= 1'b0;
		end
		else if (ms_tick_ff)
		begin
			blink_ff <= (blink_ff == `T_BLINK_MS - 1) ? 9'h0 : blink_ff + 9'h1;
			if (blink_ff == `T_BLINK_MS - 1)
				blink_ff_ph <= ~blink_ff_ph;
		end
	end

	// acknowledge latches; local ack stays here, nothing goes out on the link
	always @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			acked_ff <= {EVENTS{1'b0}};
			prev_ev_ff <= {EVENTS{1'b0}};
			silenced_ff <= 1'b0;
		end
		else
		begin
			prev_ev_ff <= ev_w;
			if (any_ack_w)
				acked_ff <= ev_w;
			else
				acked_ff <= acked_ff & ev_w;
			// a new event with its horn flag set wins over a same-cycle acknowledge
			if (|(new_ev_w & event_horn_i))
				silenced_ff <= 1'b0;
			else if (any_ack_w)
				silenced_ff <= 1'b1;
		end
	end

	// main mode sequencer
	always @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			st_ff <= S_NORMAL;
			tmr_ff <= 16'h0;
			hold_ff <= 16'h0;
			combo_ff <= 1'b0;
			sel_ff <= `GROUP_RESET;
			assigned_group_o <= `GROUP_RESET;
			lamp_cyc_ff <= 2'h0;
			lamp_step_ff <= 6'h0;
			first_cycle_ff <= 1'b1;
		end
		else
		begin
			if (both_w)
				combo_ff <= 1'b1;
			else if (!lt_ff && !ak_ff)
				combo_ff <= 1'b0;
			if (!both_w)
				hold_ff <= 16'h0;
			else if (ms_tick_ff && hold_ff != 16'hffff)
				hold_ff <= hold_ff + 16'h1;
			if (ms_tick_ff)
				tmr_ff <= tmr_ff + 16'h1;
			case (st_ff)
				S_NORMAL:
				begin
					if (both_w && hold_ff == `T_HOLD_MS)
					begin
						st_ff <= S_CONFIRM;
						sel_ff <= assigned_group_o;
						tmr_ff <= 16'h0;
					end
					else if (lt_ff && !ak_ff && !combo_ff)
					begin
						st_ff <= S_LAMP;
						tmr_ff <= 16'h0;
						lamp_cyc_ff <= 2'h0;
						lamp_step_ff <= 6'h0;
						first_cycle_ff <= 1'b1;
					end
				end
				S_LAMP:
				begin
					if (!lt_ff || ak_ff)
						st_ff <= S_NORMAL;
					else if (lamp_step_ff == 6'h0)
					begin
						// column phase: four one-second halves
						if (ms_tick_ff && tmr_ff == `T_COLUMN_MS - 1)
						begin
							tmr_ff <= 16'h0;
							lamp_cyc_ff <= lamp_cyc_ff + 2'h1;
							if (lamp_cyc_ff == 2'h3)
								lamp_step_ff <= 6'h1;
						end
					end
					else if (ms_tick_ff && tmr_ff == `T_LED_MS - 1)
					begin
						tmr_ff <= 16'h0;
						if (lamp_step_ff == LED_STEPS)
						begin
							lamp_step_ff <= 6'h0;
							lamp_cyc_ff <= 2'h0;
							first_cycle_ff <= 1'b0;
						end
						else
							lamp_step_ff <= lamp_step_ff + 6'h1;
					end
				end
				S_CONFIRM:
				begin
					if (ms_tick_ff && tmr_ff == `T_CONFIRM_MS - 1)
					begin
						st_ff <= S_SELECT;
						tmr_ff <= 16'h0;
					end
				end
				S_SELECT:
				begin
					if (both_w && hold_ff == `T_HOLD_MS)
					begin
						assigned_group_o <= sel_ff;
						st_ff <= S_EXIT;
						tmr_ff <= 16'h0;
					end
					else if (lt_ff || ak_ff)
						tmr_ff <= 16'h0;
					else if (ms_tick_ff && tmr_ff == `T_IDLE_MS - 1)
					begin
						st_ff <= S_EXIT;
						tmr_ff <= 16'h0;
					end
					if (lt_rel_w && !combo_ff)
						sel_ff <= sel_ff - 2'h1;
					else if (ak_rel_w && !combo_ff)
						sel_ff <= sel_ff + 2'h1;
				end
				S_EXIT:
				begin
					if (ms_tick_ff && tmr_ff == `T_EXITFLASH_MS - 1)
						st_ff <= S_NORMAL;
				end
				default:
					st_ff <= S_NORMAL;
			endcase
		end
	end

	// output image
	reg [ROWS-1:0] nxt_left, nxt_right;
	reg nxt_red, nxt_green, nxt_horn;
	integer i;
	always @*
	begin
		nxt_left = {ROWS{1'b0}};
		nxt_right = {ROWS{1'b0}};
		nxt_horn = 1'b0;
		nxt_red = 1'b0;
		nxt_green = 1'b0;
		// two events per row; unacked events flash, acked ones are steady
		for (i = 0; i < ROWS; i = i + 1)
		begin
			nxt_left[i] = ev_w[2*i] & (acked_ff[2*i] | blink_ff_ph);
			nxt_right[i] = ev_w[2*i+1] & (acked_ff[2*i+1] | blink_ff_ph);
		end
		nxt_horn = |(ev_w & event_horn_i) & ~silenced_ff;
		if (link_fault_i)
			nxt_red = 1'b1;
		else if (!app_loaded_i)
		begin
			nxt_red = blink_ff_ph;
			nxt_green = ~blink_ff_ph;
		end
		else if (link_lost_i)
			nxt_green = blink_ff_ph;
		else
			nxt_green = link_rx_active_i;
		case (st_ff)
			S_LAMP:
			begin
				nxt_red = 1'b0;
				nxt_green = 1'b0;
				nxt_horn = 1'b0;
				if (lamp_step_ff == 6'h0)
				begin
					nxt_left = lamp_cyc_ff[0] ? {ROWS{1'b0}} : {ROWS{1'b1}};
					nxt_right = lamp_cyc_ff[0] ? {ROWS{1'b1}} : {ROWS{1'b0}};
					nxt_horn = first_cycle_ff & lamp_cyc_ff[1];
				end
				else
				begin
					nxt_left = {ROWS{1'b0}};
					nxt_right = {ROWS{1'b0}};
					// steps 1..ROWS left down, then both status leds, then right up
					for (i = 0; i < ROWS; i = i + 1)
					begin
						nxt_left[i] = (lamp_step_ff == i + 1);
						nxt_right[i] = (lamp_step_ff == LED_STEPS - i);
					end
					nxt_red = (lamp_step_ff == ROWS + 1);
					nxt_green = (lamp_step_ff == ROWS + 2);
				end
			end
			S_CONFIRM:
			begin
				nxt_left = {ROWS{1'b0}};
				nxt_right = {ROWS{1'b0}};
				nxt_left[3:0] = {4{tmr_ff < 16'd500 || (tmr_ff % 16'd1000) < 16'd500}};
				nxt_left[3:0] = {4{(tmr_ff % 16'd1000) < 16'd500}};
				nxt_right[3:0] = nxt_left[3:0];
				nxt_horn = 1'b0;
				nxt_red = blink_ff_ph;
				nxt_green = ~blink_ff_ph;
			end
			S_SELECT:
			begin
				nxt_left = {ROWS{1'b0}};
				nxt_right = {ROWS{1'b0}};
				nxt_left[assigned_group_o] = 1'b1;
				nxt_right[sel_ff] = 1'b1;
				nxt_horn = 1'b0;
				nxt_red = blink_ff_ph;
				nxt_green = ~blink_ff_ph;
			end
			S_EXIT:
			begin
				nxt_left = {ROWS{blink_ff_ph}};
				nxt_right = {ROWS{blink_ff_ph}};
				nxt_horn = 1'b0;
			end
			default:
			begin
			end
		endcase
	end

	always @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			left_led_o <= {ROWS{1'b0}};
			right_led_o <= {ROWS{1'b0}};
			status_red_o <= 1'b0;
			status_green_o <= 1'b0;
			horn_o <= 1'b0;
			group_select_mode_o <= 1'b0;
			group_is_custom_o <= 1'b0;
		end
		else
		begin
			left_led_o <= nxt_left;
			right_led_o <= nxt_right;
			status_red_o <= nxt_red;
			status_green_o <= nxt_green;
			horn_o <= nxt_horn;
			group_select_mode_o <= (st_ff == S_CONFIRM) || (st_ff == S_SELECT);
			group_is_custom_o <= (assigned_group_o < `GROUP_FIRST_FIXED);
		end
	end
endmodule
`default_nettype wire

// *** hw/annunciator_panel_regs.vh ***
// constants for the annunciator front-panel control block
`ifndef ANNUNCIATOR_PANEL_REGS_VH
`define ANNUNCIATOR_PANEL_REGS_VH
`define CLK_HZ 10000000
`define T_COLUMN_MS 1000
`define T_LED_MS 500
`define T_HOLD_MS 3000
`define T_IDLE_MS 15000
`define T_CONFIRM_MS 4000
`define T_EXITFLASH_MS 3000
`define T_BLINK_MS 250
`define T_DEBOUNCE_MS 20
`define CYC_PER_MS (`CLK_HZ / 1000)
`define GROUP_RESET 2'h3
`define GROUP_FIRST_FIXED 2'h2
`endif

// *** verif/annunciator_panel_sva.sv ***
// assertion checker for the annunciator panel control
`timescale 1ns/1ns
`default_nettype none
module annunciator_panel_sva #(
	parameter ROWS = 16,
	parameter EVENTS = 32,
	parameter MS_CYC = 10000
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic lamp_test_button_i,
	input wire logic ack_button_i,
	input wire logic link_fault_i,
	input wire logic link_rx_active_i,
	input wire logic link_lost_i,
	input wire logic app_loaded_i,
	input wire logic global_ack_i,
	input wire logic [EVENTS-1:0] event_active_i,
	input wire logic [EVENTS-1:0] event_horn_i,
	input wire logic [ROWS-1:0] left_led_o,
	input wire logic [ROWS-1:0] right_led_o,
	input wire logic status_red_o,
	input wire logic status_green_o,
	input wire logic horn_o,
	input wire logic [1:0] assigned_group_o,
	input wire logic group_select_mode_o,
	input wire logic group_is_custom_o
);
	// buttons idle long enough that debounce and exit flash are over
	logic [31:0] idle_ff;
	wire calm = idle_ff > 40 * MS_CYC;
	wire settled = idle_ff > 3100 * MS_CYC;
	// previous event image, compared against the current one
	logic [2*EVENTS-1:0] evt_prev_ff;
	wire evt_still = {event_active_i, event_horn_i} == evt_prev_ff;
	always @(posedge core_clk_i)
		evt_prev_ff <= {event_active_i, event_horn_i};
	always @(posedge core_clk_i)
	begin
		if (!reset_n_i || lamp_test_button_i || ack_button_i || group_select_mode_o)
			idle_ff <= 32'h0;
		else if (!settled)
			idle_ff <= idle_ff + 32'h1;
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	reset_grp_a: assert property (disable iff (1'b0)
		!reset_n_i ##1 reset_n_i |-> assigned_group_o == 2'h3 && !horn_o)
		else $error("bad group after reset");
	custom_flag_a: assert property (
		$stable(assigned_group_o) ##1 $stable(assigned_group_o)
		|-> group_is_custom_o == (assigned_group_o < 2'h2))
		else $error("custom flag wrong");
	sel_status_a: assert property (
		group_select_mode_o [*3] |-> status_red_o != status_green_o)
		else $error("status pair not alternating");
	sel_rows_a: assert property (
		group_select_mode_o [*3] |-> (left_led_o >> 4) == 0 && (right_led_o >> 4) == 0)
		else $error("lower rows lit in select");
	gack_horn_a: assert property (
		calm && global_ack_i && evt_still ##1 evt_still |=> !horn_o)
		else $error("horn on after global ack");
	horn_hold_a: assert property (
		(settled && evt_still) [*3] ##0 !horn_o |=> !horn_o)
		else $error("horn rose with no new event");
	fault_red_a: assert property (
		(settled && app_loaded_i && link_fault_i) [*2] |-> status_red_o && !status_green_o)
		else $error("no solid red on fault");
	rx_green_a: assert property (
		(settled && app_loaded_i && !link_fault_i && !link_lost_i && link_rx_active_i) [*2]
		|-> status_green_o && !status_red_o)
		else $error("no green while receiving");
endmodule
bind annunciator_panel annunciator_panel_sva #(.ROWS(ROWS), .EVENTS(EVENTS), .MS_CYC(MS_CYC))
	sva_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
	.lamp_test_button_i(lamp_test_button_i), .ack_button_i(ack_button_i),
	.link_fault_i(link_fault_i), .link_rx_active_i(link_rx_active_i),
	.link_lost_i(link_lost_i),
	.app_loaded_i(app_loaded_i), .global_ack_i(global_ack_i),
	.event_active_i(event_active_i), .event_horn_i(event_horn_i),
	.left_led_o(left_led_o), .right_led_o(right_led_o), .status_red_o(status_red_o),
	.status_green_o(status_green_o), .horn_o(horn_o), .assigned_group_o(assigned_group_o),
	.group_select_mode_o(group_select_mode_o), .group_is_custom_o(group_is_custom_o));
`default_nettype wire

// *** verif/link_partner.sv ***
// far-side model: controller link status, events and global acknowledge
`timescale 1ns/1ns
`default_nettype none
module link_partner (
	input wire logic core_clk_i,
	output logic link_fault_o,
	output logic link_rx_active_o,
	output logic link_lost_o,
	output logic app_loaded_o,
	output logic global_ack_o,
	output logic [31:0] event_active_o,
	output logic [31:0] event_horn_o,
	output logic [1:0] event_group_o
);
	initial
	begin
		{link_fault_o, link_rx_active_o, link_lost_o, app_loaded_o, global_ack_o} = 5'h0a;
		event_active_o = 32'h0;
		event_horn_o = 32'h0;
		event_group_o = 2'h3;
	end
	task st(input logic f, r, l, a);
		{link_fault_o, link_rx_active_o, link_lost_o, app_loaded_o} = {f, r, l, a};
	endtask
	// events arrive already mapped to the assigned group
	task ev(input logic [31:0] a, h);
		event_active_o = a;
		event_horn_o = h;
	endtask
	// one-cycle broadcast, may reach several annunciators at once
	task gack;
		global_ack_o = 1'b1;
		@(posedge core_clk_i);
		#10 global_ack_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// *** verif/annunciator_panel_tb.sv ***
// self-checking bench for the annunciator panel control
`timescale 1ns/1ns
`default_nettype none
module annunciator_panel_tb;
	localparam int MS = 1;
	logic core_clk_i = 0, reset_n_i = 0, lbtn = 0, abtn = 0, b;
	logic fault, rxa, lost, app, gack, red, grn, horn, sel, cust;
	logic [31:0] eva, evh;
	logic [1:0] evg, grp;
	logic [15:0] lft, rgt;
	int fails = 0, comparisons = 0, k, j, c;
	always #50 core_clk_i = ~core_clk_i;
	link_partner peer (.core_clk_i(core_clk_i), .link_fault_o(fault), .link_rx_active_o(rxa),
		.link_lost_o(lost), .app_loaded_o(app), .global_ack_o(gack), .event_active_o(eva),
		.event_horn_o(evh), .event_group_o(evg));
	annunciator_panel #(.MS_CYC(MS)) dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.lamp_test_button_i(lbtn), .ack_button_i(abtn), .link_fault_i(fault),
		.link_rx_active_i(rxa), .link_lost_i(lost), .app_loaded_i(app), .global_ack_i(gack),
		.event_active_i(eva), .event_horn_i(evh), .event_group_i(evg), .left_led_o(lft),
		.right_led_o(rgt), .status_red_o(red), .status_green_o(grn), .horn_o(horn),
		.assigned_group_o(grp), .group_select_mode_o(sel), .group_is_custom_o(cust));
	task tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#10;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// actions are taken at release, after the debounce
	task press(input logic l, a);
		{lbtn, abtn} = {l, a};
		tick(40 * MS);
		{lbtn, abtn} = 2'b00;
		tick(40 * MS);
	endtask
	task hold2;
		{lbtn, abtn} = 2'b11;
		tick(1500 * MS);
		chk({lft == 16'hffff, horn}, 0);
		tick(1600 * MS);
		{lbtn, abtn} = 2'b00;
		tick(40 * MS);
	endtask
	task t_status;
		peer.st(1, 0, 0, 1);
		tick(5);
		chk({red, grn}, 2'b10);
		peer.st(0, 1, 0, 1);
		tick(5);
		chk({red, grn}, 2'b01);
		peer.st(0, 0, 1, 1);
		tick(5);
		b = grn;
		for (k = 0; k < 300 * MS && grn === b; k++) tick(1);
		chk({red, grn}, {1'b0, ~b});
		peer.st(0, 1, 0, 0);
		tick(5);
		chk(red ^ grn, 1);
		peer.st(0, 1, 0, 1);
	endtask
	task t_ack;
		peer.ev(32'h1, 32'h1);
		tick(5);
		chk(horn, 1);
		press(0, 1);
		chk(horn, 0);
		b = 1;
		for (k = 0; k < 300 * MS; k++)
		begin
			b = b & lft[0];
			tick(1);
		end
		chk(b, 1);
		peer.ev(32'h3, 32'h3);
		tick(5);
		chk(horn, 1);
		peer.gack;
		tick(100);
		chk(horn, 0);
		tick(3200 * MS);
		chk(horn, 0);
		peer.ev(32'h0, 32'h0);
	endtask
	task t_lamp;
		lbtn = 1;
		for (k = 0; k < 100 * MS && lft !== 16'hffff; k++) tick(1);
		chk(lft, 16'hffff);
		tick(250 * MS);
		for (c = 0; c < 2; c++)
		begin
			for (j = 0; j < 4; j++)
			begin
				chk({lft, rgt, horn}, {j[0] ? 32'h0000ffff : 32'hffff0000, c == 0 && j > 1});
				tick(1000 * MS);
			end
			for (j = 0; j < 34 && c == 0; j++)
			begin
				chk({lft, rgt, red, grn}, 64'h1 << (j < 16 ? 18 + j : j < 18 ? 17 - j : 35 - j));
				tick(500 * MS);
			end
		end
		lbtn = 0;
		tick(40 * MS);
		chk({lft, rgt, horn}, 0);
	endtask
	task t_select;
		hold2;
		chk(sel, 1);
		b = 0;
		for (k = 0; k < 3000 * MS; k++)
		begin
			b = b | (lft === 16'h000f);
			tick(1);
		end
		chk(b, 1);
		tick(1500 * MS);
		chk({lft, rgt}, 32'h00080008);
		press(0, 1);
		chk(rgt, 16'h1);
		press(1, 0);
		press(1, 0);
		chk({lft, rgt}, 32'h00080004);
		tick(14800 * MS);
		chk(sel, 1);
		tick(300 * MS);
		chk({sel, grp}, 3'h3);
		b = 0;
		for (k = 0; k < 2000 * MS; k++)
		begin
			b = b | (lft === 16'hffff);
			tick(1);
		end
		chk(b, 1);
		tick(1500 * MS);
		chk(lft, 16'h0);
		hold2;
		tick(4500 * MS);
		press(0, 1);
		press(0, 1);
		chk(rgt, 16'h2);
		hold2;
		chk({sel, grp, cust}, 4'h3);
	endtask
	initial
	begin
		#9000000;
		fails++;
		test_done;
	end
	initial
	begin
		tick(10);
		reset_n_i = 1;
		chk({grp, cust}, 3'h6);
		tick(3200 * MS);
		t_status;
		t_ack;
		t_lamp;
		t_select;
		test_done;
	end
endmodule
`default_nettype wire
